// File: src/pfs_pkg.sv
// Shared constants and types of the program flow sequencer
package pfs_pkg;

    // Widths and depths
    localparam int PFS_PC_W = 12;
    localparam int PFS_STACK_DEPTH = 8;
    localparam int PFS_LABEL_W = 9;

    // File addresses of the internal registers
    localparam logic [7:0] PFS_ADDR_STATUS = 8'h03;
    localparam logic [7:0] PFS_ADDR_INDPTR = 8'h04;

    // Status register field positions
    localparam int PFS_BIT_CARRY = 0;
    localparam int PFS_BIT_HALFC = 1;
    localparam int PFS_BIT_ZERO = 2;
    localparam int PFS_BIT_PDOWN = 3;
    localparam int PFS_BIT_WDEXP = 4;
    localparam int PFS_PAGE_LSB = 5;
    localparam int PFS_PAGE_MSB = 7;

    // Bank field position in the indirect pointer
    localparam int PFS_BANK_LSB = 4;
    localparam int PFS_BANK_MSB = 6;

    // Reset values
    localparam logic [11:0] PFS_PC_RESET = 12'h000;
    localparam logic [7:0] PFS_STATUS_RESET = 8'h00;
    localparam logic [7:0] PFS_INDPTR_RESET = 8'h00;
    localparam logic [7:0] PFS_WORK_RESET = 8'h00;

    // Decoded operations presented by instruction decode
    typedef enum logic [4:0] {
        OP_NOP,
        OP_JUMP,
        OP_CALL,
        OP_PAGE_SEL,
        OP_BANK_SEL,
        OP_SUB_EXIT,
        OP_EXIT_PAGE,
        OP_INT_EXIT,
        OP_INT_EXIT_ADD,
        OP_EXIT_LIT,
        OP_DEC_SKZ,
        OP_INC_SKZ,
        OP_SKIP_SET,
        OP_SKIP_CLR,
        OP_AND,
        OP_OR,
        OP_XOR,
        OP_ROT_L,
        OP_ROT_R,
        OP_COMP_F,
        OP_COMP_W,
        OP_SWAP_W,
        OP_MOV_TO_F,
        OP_BIT_SET,
        OP_BIT_CLR
    } pfs_op_t;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_RUN,
        ST_FLUSH,
        ST_SKIP
    } pfs_state_t;

endpackage

// File: src/pfs_alu.sv
// Combinational datapath for logic, rotate, complement and skip tests
`timescale 1ns/100ps
module pfs_alu
    import pfs_pkg::*;
(
    input wire pfs_op_t op,
    input wire logic [7:0] fileVal,
    input wire logic [7:0] workVal,
    input wire logic carryIn,
    input wire logic [2:0] bitSel,
    output logic [7:0] result,
    output logic carryOut,
    output logic zeroOut,
    output logic skipCond
);

    // Result, carry and skip condition per operation
    always_comb begin
        result = fileVal;
        carryOut = carryIn;
        skipCond = 1'b0;
        case (op)
            OP_AND: result = workVal & fileVal;
            OP_OR: result = workVal | fileVal;
            OP_XOR: result = workVal ^ fileVal;
            OP_ROT_L: begin
                result = {fileVal[6:0], carryIn};
                carryOut = fileVal[7];
            end
            OP_ROT_R: begin
                result = {carryIn, fileVal[7:1]};
                carryOut = fileVal[0];
            end
            OP_COMP_F: result = ~fileVal;
            OP_COMP_W: result = ~workVal;
            OP_SWAP_W: result = {fileVal[3:0], fileVal[7:4]};
            OP_MOV_TO_F: result = workVal;
            OP_BIT_SET: result = fileVal | (8'h01 << bitSel);
            OP_BIT_CLR: result = fileVal & ~(8'h01 << bitSel);
            OP_DEC_SKZ: begin
                result = fileVal - 8'h01;
                skipCond = (result == 8'h00);
            end
            OP_INC_SKZ: begin
                result = fileVal + 8'h01;
                skipCond = (result == 8'h00);
            end
            OP_SKIP_SET: skipCond = fileVal[bitSel];
            OP_SKIP_CLR: skipCond = ~fileVal[bitSel];
            default: result = fileVal;
        endcase
    end

    // Zero flag of the result
    assign zeroOut = (result == 8'h00);

endmodule

// File: src/program_flow_sequencer.sv
// Program counter, return stack, skip sequencing and status of the core
`timescale 1ns/100ps
module program_flow_sequencer
    import pfs_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic instrValid,
    input wire pfs_op_t instrOp,
    input wire logic [8:0] instrLabel,
    input wire logic [7:0] instrLiteral,
    input wire logic [7:0] instrFileAddr,
    input wire logic instrToFile,
    input wire logic [2:0] instrBit,
    input wire logic [7:0] fileRdData,
    input wire logic powerDown,
    input wire logic watchdogExpiry,
    output logic instrReady,
    output logic [11:0] fetchAddr,
    output logic [7:0] workReg,
    output logic [7:0] statusReg,
    output logic [7:0] indirectPtr,
    output logic fileWrEn,
    output logic [7:0] fileWrAddr,
    output logic [7:0] fileWrData,
    output logic rtcAddEn,
    output logic [7:0] rtcAddValue
);

    // True for the file addresses held inside this block
    function automatic logic isInternal(input logic [7:0] addr);
        return (addr == PFS_ADDR_STATUS) || (addr == PFS_ADDR_INDPTR);
    endfunction

    // True for the page and bank prefix instructions
    function automatic logic isPrefix(input pfs_op_t op);
        return (op == OP_PAGE_SEL) || (op == OP_BANK_SEL);
    endfunction

    pfs_state_t state, next_state;
    logic [11:0] pc, next_pc;
    logic [11:0] stack [PFS_STACK_DEPTH];
    logic [11:0] next_stack [PFS_STACK_DEPTH];
    logic [7:0] next_workReg, next_statusReg, next_indirectPtr;
    logic next_fileWrEn, next_rtcAddEn;
    logic [7:0] next_fileWrAddr, next_fileWrData, next_rtcAddValue;
    logic [7:0] fileVal, aluResult;
    logic aluCarry, aluZero, aluSkip, execValid;
    logic [11:0] pcPlusOne;
    logic [2:0] pageSel;

    // internal registers answer their file addresses
    always_comb begin
        fileVal = fileRdData;
        if (instrFileAddr == PFS_ADDR_STATUS) begin
            fileVal = statusReg;
        end else if (instrFileAddr == PFS_ADDR_INDPTR) begin
            fileVal = indirectPtr;
        end
    end

    pfs_alu alu (
        .op(instrOp),
        .fileVal(fileVal),
        .workVal(workReg),
        .carryIn(statusReg[PFS_BIT_CARRY]),
        .bitSel(instrBit),
        .result(aluResult),
        .carryOut(aluCarry),
        .zeroOut(aluZero),
        .skipCond(aluSkip)
    );

    // Handshake and execute qualifiers
    assign instrReady = (state != ST_FLUSH);
    assign execValid = instrValid && (state == ST_RUN);
    assign pcPlusOne = pc + 12'h001;
    assign pageSel = statusReg[PFS_PAGE_MSB:PFS_PAGE_LSB];
    assign fetchAddr = pc;

    // Next state of the whole sequencer
    always_comb begin
        next_state = state;
        next_pc = pc;
        next_stack = stack;
        next_workReg = workReg;
        next_statusReg = statusReg;
        next_indirectPtr = indirectPtr;
        next_fileWrEn = 1'b0;
        next_fileWrAddr = fileWrAddr;
        next_fileWrData = fileWrData;
        next_rtcAddEn = 1'b0;
        next_rtcAddValue = rtcAddValue;
        case (state)
            ST_FLUSH: begin
                // one refill cycle after a redirect
                next_state = ST_RUN;
            end
            ST_SKIP: begin
                if (instrValid) begin
                    next_pc = pcPlusOne;
                    next_state = isPrefix(instrOp) ? ST_SKIP : ST_RUN;
                end
            end
            ST_RUN: begin
                if (execValid) begin
                    next_pc = pcPlusOne;
                    case (instrOp)
                        OP_JUMP: begin
                            // page bits as before the jump
                            next_pc = {pageSel, instrLabel};
                            next_state = ST_FLUSH;
                        end
                        OP_CALL: begin
                            next_pc = {pageSel, 1'b0, instrLabel[7:0]};
                            next_stack[0] = pcPlusOne;
                            for (int i = 1; i < PFS_STACK_DEPTH; i++) begin
                                next_stack[i] = stack[i-1];
                            end
                            next_state = ST_FLUSH;
                        end
                        OP_SUB_EXIT, OP_EXIT_PAGE, OP_INT_EXIT,
                        OP_INT_EXIT_ADD, OP_EXIT_LIT: begin
                            next_pc = stack[0];
                            for (int i = 0; i < PFS_STACK_DEPTH - 1; i++) begin
                                next_stack[i] = stack[i+1];
                            end
                            next_state = ST_FLUSH;
                            if (instrOp == OP_EXIT_PAGE) begin
                                next_statusReg[PFS_PAGE_MSB:PFS_PAGE_LSB] =
                                    stack[0][11:9];
                            end
                            if (instrOp == OP_EXIT_LIT) begin
                                next_workReg = instrLiteral;
                            end
                            if (instrOp == OP_INT_EXIT_ADD) begin
                                next_rtcAddEn = 1'b1;
                                next_rtcAddValue = workReg;
                            end
                        end
                        OP_PAGE_SEL: begin
                            next_statusReg[PFS_PAGE_MSB:PFS_PAGE_LSB] =
                                instrLiteral[2:0];
                        end
                        OP_BANK_SEL: begin
                            next_indirectPtr[PFS_BANK_MSB:PFS_BANK_LSB] =
                                instrLiteral[2:0];
                        end
                        OP_SKIP_SET, OP_SKIP_CLR: begin
                            if (aluSkip) begin
                                next_state = ST_SKIP;
                            end
                        end
                        OP_NOP: next_state = ST_RUN;
                        default: begin
                            // Datapath writeback to W or file
                            if ((instrToFile && instrOp != OP_SWAP_W) ||
                                instrOp == OP_MOV_TO_F) begin
                                if (instrFileAddr == PFS_ADDR_STATUS) begin
                                    next_statusReg = aluResult;
                                end else if (instrFileAddr ==
                                             PFS_ADDR_INDPTR) begin
                                    next_indirectPtr = aluResult;
                                end
                                next_fileWrEn = !isInternal(instrFileAddr);
                                next_fileWrAddr = instrFileAddr;
                                next_fileWrData = aluResult;
                            end else begin
                                next_workReg = aluResult;
                            end
                            case (instrOp)
                                OP_AND, OP_OR, OP_XOR, OP_COMP_F,
                                OP_COMP_W: begin
                                    next_statusReg[PFS_BIT_ZERO] = aluZero;
                                end
                                OP_ROT_L, OP_ROT_R: begin
                                    next_statusReg[PFS_BIT_CARRY] = aluCarry;
                                end
                                default: ; // Other ops keep flags
                            endcase
                            if ((instrOp == OP_DEC_SKZ ||
                                 instrOp == OP_INC_SKZ) && aluSkip) begin
                                next_state = ST_SKIP;
                            end
                        end
                    endcase
                end
            end
            default: next_state = ST_RUN;
        endcase
        next_statusReg[PFS_BIT_PDOWN] = powerDown;
        next_statusReg[PFS_BIT_WDEXP] = watchdogExpiry;
    end

    // Register all sequencer state
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= ST_RUN;
            pc <= PFS_PC_RESET;
            for (int i = 0; i < PFS_STACK_DEPTH; i++) begin
                stack[i] <= PFS_PC_RESET;
            end
            workReg <= PFS_WORK_RESET;
            statusReg <= PFS_STATUS_RESET;
            indirectPtr <= PFS_INDPTR_RESET;
            fileWrEn <= 1'b0;
            fileWrAddr <= 8'h00;
            fileWrData <= 8'h00;
            rtcAddEn <= 1'b0;
            rtcAddValue <= 8'h00;
        end else begin
            state <= next_state;
            pc <= next_pc;
            stack <= next_stack;
            workReg <= next_workReg;
            statusReg <= next_statusReg;
            indirectPtr <= next_indirectPtr;
            fileWrEn <= next_fileWrEn;
            fileWrAddr <= next_fileWrAddr;
            fileWrData <= next_fileWrData;
            rtcAddEn <= next_rtcAddEn;
            rtcAddValue <= next_rtcAddValue;
        end
    end

    // Jump target and page source
    jump_target_a: assert property (
        @(posedge clk) disable iff (reset)
        execValid && instrOp == OP_JUMP |=>
            fetchAddr == {$past(pageSel), $past(instrLabel)}
            && !instrReady ##1 instrReady)
        else $error("jump target or refill wrong");

    // Call target in lower half page
    call_target_a: assert property (
        @(posedge clk) disable iff (reset)
        execValid && instrOp == OP_CALL |=>
            fetchAddr[8] == 1'b0 && fetchAddr[11:9] == $past(pageSel)
            && fetchAddr[7:0] == $past(instrLabel[7:0]))
        else $error("call target wrong");

    // Call push and stack shift
    call_push_a: assert property (
        @(posedge clk) disable iff (reset)
        execValid && instrOp == OP_CALL |=>
            stack[0] == $past(pc) + 12'h001 && stack[1] == $past(stack[0])
            && stack[7] == $past(stack[6]))
        else $error("call push wrong");

    // Pop loads level one, level eight held
    return_pop_a: assert property (
        @(posedge clk) disable iff (reset)
        execValid && instrOp == OP_SUB_EXIT |=>
            fetchAddr == $past(stack[0]) && stack[6] == $past(stack[7])
            && stack[7] == $past(stack[7]) && workReg == $past(workReg))
        else $error("return pop wrong");

    // Page operand written in one cycle
    page_write_a: assert property (
        @(posedge clk) disable iff (reset)
        execValid && instrOp == OP_PAGE_SEL |=>
            pageSel == $past(instrLiteral[2:0]) && instrReady)
        else $error("page select write wrong");

    // Literal exit loads W
    literal_exit_a: assert property (
        @(posedge clk) disable iff (reset)
        execValid && instrOp == OP_EXIT_LIT |=>
            workReg == $past(instrLiteral))
        else $error("literal exit wrong");

    // Interrupt exit add request
    counter_add_a: assert property (
        @(posedge clk) disable iff (reset)
        execValid && instrOp == OP_INT_EXIT_ADD |=>
            rtcAddEn && rtcAddValue == $past(workReg) ##1 !rtcAddEn)
        else $error("counter add wrong");

    // Taken skip drops a prefix and the instruction after it
    skip_taken_a: assert property (
        @(posedge clk) disable iff (reset)
        execValid && instrOp == OP_SKIP_SET && aluSkip ##1
            instrValid && isPrefix(instrOp) ##1
            instrValid && !isPrefix(instrOp)
            |=> state == ST_RUN && workReg == $past(workReg, 2))
        else $error("skip over prefix wrong");

    // Nibble swap into W
    swap_move_a: assert property (
        @(posedge clk) disable iff (reset)
        execValid && instrOp == OP_SWAP_W |=>
            workReg == {$past(fileVal[3:0]), $past(fileVal[7:4])})
        else $error("nibble swap wrong");

    // Hardware flags in bits three and four
    hw_flags_a: assert property (
        @(posedge clk) disable iff (reset)
        ##1 statusReg[PFS_BIT_PDOWN] == $past(powerDown)
            && statusReg[PFS_BIT_WDEXP] == $past(watchdogExpiry))
        else $error("status hardware flags wrong");

endmodule

// File: test/tb_top.sv
// Self-checking bench with a behavioural model of the sequencer
`timescale 1ns/100ps
module tb_top;
    import pfs_pkg::*;
    logic clk, reset, instrValid, instrToFile, powerDown, watchdogExpiry;
    pfs_op_t instrOp;
    logic [8:0] instrLabel;
    logic [7:0] instrLiteral, instrFileAddr, fileRdData;
    logic [2:0] instrBit;
    logic instrReady, fileWrEn, rtcAddEn;
    logic [11:0] fetchAddr;
    logic [7:0] workReg, statusReg, indirectPtr, fileWrAddr, fileWrData;
    logic [7:0] rtcAddValue;
    int num_errors = 0;
    int tests_run = 0;
    // Model state
    logic [11:0] mPc;
    logic [11:0] mStk [8];
    logic [7:0] mW, mSt, mInd, eWa, eWd, eRv;
    bit mFlush, mSkip, eWr, eRtc;
    // Instruction valid for the next step
    bit iv = 1'b1;

    program_flow_sequencer i_dut (.clk(clk), .reset(reset),
        .instrValid(instrValid), .instrOp(instrOp), .instrLabel(instrLabel),
        .instrLiteral(instrLiteral), .instrFileAddr(instrFileAddr),
        .instrToFile(instrToFile), .instrBit(instrBit),
        .fileRdData(fileRdData), .powerDown(powerDown),
        .watchdogExpiry(watchdogExpiry), .instrReady(instrReady),
        .fetchAddr(fetchAddr), .workReg(workReg), .statusReg(statusReg),
        .indirectPtr(indirectPtr), .fileWrEn(fileWrEn),
        .fileWrAddr(fileWrAddr), .fileWrData(fileWrData),
        .rtcAddEn(rtcAddEn), .rtcAddValue(rtcAddValue));

    // Clock of 20 ns
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end

    // Compare one value
    task automatic chk(string what, logic [11:0] exp, logic [11:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Verdict and end of run
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Drive one instruction, advance model, compare results
    task automatic step(pfs_op_t op, logic [8:0] lab, logic [7:0] lit,
                        logic [7:0] fa, logic tof, logic [2:0] bn,
                        logic [7:0] frd);
        logic [8:0] r;
        logic [11:0] old;
        int dst;
        int zf;
        int cf;
        logic [7:0] fv;
        @(negedge clk);
        instrValid = iv;
        instrOp = op;
        instrLabel = lab;
        instrLiteral = lit;
        instrFileAddr = fa;
        instrToFile = tof;
        instrBit = bn;
        fileRdData = frd;
        powerDown = 1'($urandom);
        watchdogExpiry = 1'($urandom);
        chk("instrReady", 12'(!mFlush), 12'(instrReady));
        eWr = 0;
        eRtc = 0;
        dst = 0;
        zf = 0;
        cf = 0;
        r = 9'h000;
        // Internal registers answer their own addresses
        fv = (fa == PFS_ADDR_STATUS) ? mSt :
             (fa == PFS_ADDR_INDPTR) ? mInd : frd;
        if (mFlush) begin
            mFlush = 0;
        end else if (!instrValid) begin
            // Idle cycle changes nothing
        end else if (mSkip) begin
            mPc++;
            mSkip = op inside {OP_PAGE_SEL, OP_BANK_SEL};
        end else if (op == OP_JUMP) begin
            mPc = {mSt[7:5], lab};
            mFlush = 1;
        end else if (op == OP_CALL) begin
            for (int i = 7; i > 0; i--) mStk[i] = mStk[i-1];
            mStk[0] = mPc + 12'h001;
            mPc = {mSt[7:5], 1'b0, lab[7:0]};
            mFlush = 1;
        end else if (op inside {OP_SUB_EXIT, OP_EXIT_PAGE, OP_INT_EXIT,
                                OP_INT_EXIT_ADD, OP_EXIT_LIT}) begin
            old = mStk[0];
            for (int i = 0; i < 7; i++) mStk[i] = mStk[i+1];
            mPc = old;
            mFlush = 1;
            if (op == OP_EXIT_LIT) mW = lit;
            if (op == OP_EXIT_PAGE) mSt[7:5] = old[11:9];
            eRtc = (op == OP_INT_EXIT_ADD);
            eRv = mW;
        end else begin
            mPc++;
            case (op)
                OP_PAGE_SEL: mSt[7:5] = lit[2:0];
                OP_BANK_SEL: mInd[6:4] = lit[2:0];
                OP_DEC_SKZ, OP_INC_SKZ: begin
                    r = (op == OP_DEC_SKZ) ? fv - 8'h01 : fv + 8'h01;
                    dst = tof + 1;
                    mSkip = (r[7:0] == 8'h00);
                end
                OP_SKIP_SET: mSkip = fv[bn];
                OP_SKIP_CLR: mSkip = !fv[bn];
                OP_AND, OP_OR, OP_XOR, OP_COMP_F: begin
                    r = op == OP_AND ? fv & mW : op == OP_OR ? fv | mW :
                        op == OP_XOR ? fv ^ mW : ~fv;
                    dst = tof + 1;
                    zf = 1;
                end
                OP_ROT_L, OP_ROT_R: begin
                    r = op == OP_ROT_L ? {fv, mSt[0]}
                                       : {fv[0], mSt[0], fv[7:1]};
                    dst = tof + 1;
                    cf = 1;
                end
                OP_COMP_W: begin
                    r = {1'b0, ~mW};
                    dst = tof + 1;
                    zf = 1;
                end
                OP_SWAP_W: begin
                    r = {1'b0, fv[3:0], fv[7:4]};
                    dst = 1;
                end
                OP_MOV_TO_F: begin
                    r = {1'b0, mW};
                    dst = 2;
                end
                OP_BIT_SET, OP_BIT_CLR: begin
                    r = {1'b0, fv};
                    r[bn] = (op == OP_BIT_SET);
                    dst = 2;
                end
                default: ;
            endcase
            if (dst == 1) mW = r[7:0];
            if (dst == 2 && fa == PFS_ADDR_STATUS) mSt = r[7:0];
            if (dst == 2 && fa == PFS_ADDR_INDPTR) mInd = r[7:0];
            eWr = dst == 2 && !(fa inside {PFS_ADDR_STATUS, PFS_ADDR_INDPTR});
            eWa = fa;
            eWd = r[7:0];
            if (zf) mSt[PFS_BIT_ZERO] = (r[7:0] == 8'h00);
            if (cf) mSt[PFS_BIT_CARRY] = r[8];
        end
        mSt[PFS_BIT_PDOWN] = powerDown;
        mSt[PFS_BIT_WDEXP] = watchdogExpiry;
        @(posedge clk);
        #1;
        chk("fetchAddr", mPc, fetchAddr);
        chk("workReg", 12'(mW), 12'(workReg));
        chk("statusReg", 12'(mSt), 12'(statusReg));
        chk("indirectPtr", 12'(mInd), 12'(indirectPtr));
        chk("fileWrEn", 12'(eWr), 12'(fileWrEn));
        if (eWr) chk("fileWrAddr", 12'(eWa), 12'(fileWrAddr));
        if (eWr) chk("fileWrData", 12'(eWd), 12'(fileWrData));
        chk("rtcAddEn", 12'(eRtc), 12'(rtcAddEn));
        if (eRtc) chk("rtcAddValue", 12'(eRv), 12'(rtcAddValue));
    endtask

    // Simple instruction with default operands
    task automatic op1(pfs_op_t op, logic [8:0] lab, logic [7:0] lit);
        step(op, lab, lit, 8'h10, 1'b1, 3'h2, 8'h04);
    endtask

    // Random instruction of any kind
    task automatic rstep();
        pfs_op_t op;
        logic [7:0] fa;
        op = pfs_op_t'($urandom_range(0, 24));
        fa = 8'($urandom_range(8, 31));
        if ($urandom_range(0, 3) == 0) fa = 8'($urandom_range(3, 4));
        iv = ($urandom_range(0, 7) != 0);
        step(op, 9'($urandom), 8'($urandom), fa,
             op inside {OP_BIT_SET, OP_BIT_CLR} || 1'($urandom),
             3'($urandom), 8'($urandom));
        iv = 1'b1;
    endtask

    // Hang guard
    initial begin
        #(20ns * 20000);
        num_errors++;
        end_of_test();
    end

    // Main sequence
    initial begin
        {instrValid, instrToFile, powerDown, watchdogExpiry} = 4'h0;
        instrOp = OP_NOP;
        {instrLabel, instrLiteral, instrFileAddr, fileRdData} = '0;
        instrBit = 3'h0;
        mPc = PFS_PC_RESET;
        for (int i = 0; i < 8; i++) mStk[i] = 12'h000;
        {mW, mSt, mInd} = '0;
        {mFlush, mSkip} = 2'b00;
        void'($urandom(32'h2127));
        reset = 1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        reset = 0;
        // Page select then jump and call, pages zero to three of the eight
        for (int p = 0; p < 4; p++) begin
            op1(OP_PAGE_SEL, 9'h000, 8'(p));
            op1(OP_JUMP, 9'h1A5 ^ 9'(p), 8'h00);
            op1(OP_NOP, 9'h000, 8'h00);
            op1(OP_CALL, 9'h1C3, 8'h00);
            op1(OP_NOP, 9'h000, 8'h00);
        end
        op1(OP_COMP_W, 9'h000, 8'h00);
        step(OP_MOV_TO_F, 9'h0, 8'h0, 8'h03, 1'b1, 3'h0, 8'h0);
        $display("test pages and jumps done");
        // Nine nested calls then ten returns of every kind
        for (int i = 0; i < 9; i++) begin
            op1(OP_CALL, 9'(i * 37), 8'h00);
            op1(OP_NOP, 9'h000, 8'h00);
        end
        for (int i = 0; i < 10; i++) begin
            op1(pfs_op_t'(int'(OP_SUB_EXIT) + i % 5), 9'h0, 8'(i));
            op1(OP_NOP, 9'h000, 8'h00);
        end
        $display("test stack over and underflow done");
        // Taken skips over prefixes and a skip not taken
        step(OP_SKIP_SET, 9'h0, 8'h0, 8'h12, 1'b0, 3'h2, 8'h04);
        op1(OP_PAGE_SEL, 9'h000, 8'h01);
        op1(OP_BANK_SEL, 9'h000, 8'h05);
        op1(OP_COMP_W, 9'h000, 8'h00);
        step(OP_SKIP_SET, 9'h0, 8'h0, 8'h12, 1'b0, 3'h2, 8'h04);
        op1(OP_PAGE_SEL, 9'h000, 8'h02);
        op1(OP_COMP_W, 9'h000, 8'h00);
        step(OP_DEC_SKZ, 9'h0, 8'h0, 8'h12, 1'b0, 3'h0, 8'h01);
        op1(OP_COMP_W, 9'h000, 8'h00);
        step(OP_SKIP_CLR, 9'h0, 8'h0, 8'h12, 1'b0, 3'h2, 8'h04);
        step(OP_INC_SKZ, 9'h0, 8'h0, 8'h12, 1'b1, 3'h0, 8'hFF);
        op1(OP_COMP_W, 9'h000, 8'h00);
        $display("test skips done");
        // Random instruction stream
        for (int i = 0; i < 4000; i++) rstep();
        $display("test random stream done");
        end_of_test();
    end
endmodule
